// ### src/mdc_regs.sv
// Configuration register bank of a sensorless motor controller.
// Assumes one 10 MHz clock, a strobe register port and fault inputs
// from logic on the same clock; the outside clock pin is asynchronous.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps

// Function
// - Fault setting steers speed feedback pin
// - Max frequency field is full-speed hertz
// - Spread spectrum on when bit is 0
// - Mode bit selects standby or sleep
// - Band bit selects speed PWM range
// - Clock source internal at 0, external 3
// - Outside clock used only when enabled
// - Outside clock rate 8 kHz doubling
// - Gate word one at ACh, reset 00228000h
// - Gate word two at AEh, reset 01200000h
// - Device word at A8h, reset zero
// - Frequency mode when speed source is 3
module mdc_regs
(
  input  wire logic                         sys_clk_in,
  input  wire logic                         reset_n_in,
  input  wire logic [mdc_pkg::MDC_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]                  wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [31:0]                  rdata_out,
  input  wire logic                         fault_in,
  input  wire logic                         motor_stopped_in,
  input  wire logic                         fb_tick_in,
  input  wire logic [1:0]                   speed_input_source_in,
  input  wire logic                         outside_clock_pin_in,
  output logic                              speed_feedback_output_out,
  output logic                              speed_feedback_oe_out,
  output logic      [14:0]                  full_speed_hz_out,
  output logic                              freq_mode_out,
  output logic                              sleep_select_out,
  output logic      [16:0]                  pwm_min_hz_out,
  output logic      [16:0]                  pwm_max_hz_out,
  output logic                              outside_clock_out,
  output mdc_pkg::mdc_clk_cfg_t             clk_cfg_out
);

  mdc_pkg::mdc_state_t s_q;
  mdc_pkg::mdc_state_t s_d;

  logic [1:0] fb_mode;
  logic [1:0] clk_src;
  logic [2:0] ext_rate;
  logic       sel_ok;
  logic [7:0] sel_idx;

  // Field views of the stored words.
  assign fb_mode  = s_q.pin_setup_two[mdc_pkg::MDC_FB_FAULT_LSB +: 2];
  assign clk_src  = s_q.device_setup[mdc_pkg::MDC_CLK_SRC_LSB +: 2];
  assign ext_rate = s_q.device_setup[mdc_pkg::MDC_EXT_RATE_LSB +: 3];
  assign sel_ok   = (addr_in[1:0] == 2'h0);
  assign sel_idx  = addr_in[9:2];

  // Next-state logic: bus writes, read data and the feedback pin.
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    // Whole words are stored, so reserved bits read back as written.
    if (wr_in && sel_ok)
    begin
      case (sel_idx)
        mdc_pkg::MDC_IDX_PIN_SETUP_TWO: s_d.pin_setup_two = wdata_in;
        mdc_pkg::MDC_IDX_DEVICE_SETUP:  s_d.device_setup  = wdata_in;
        mdc_pkg::MDC_IDX_GATE_ONE:      s_d.gate_one      = wdata_in;
        mdc_pkg::MDC_IDX_GATE_TWO:      s_d.gate_two      = wdata_in;
        default:                        s_d.rdata         = 32'h0000_0000;
      endcase
    end
    // Unmapped reads answer zero rather than stalling the master.
    if (rd_in && sel_ok)
    begin
      case (sel_idx)
        mdc_pkg::MDC_IDX_PIN_SETUP_TWO: s_d.rdata = s_q.pin_setup_two;
        mdc_pkg::MDC_IDX_DEVICE_SETUP:  s_d.rdata = s_q.device_setup;
        mdc_pkg::MDC_IDX_GATE_ONE:      s_d.rdata = s_q.gate_one;
        mdc_pkg::MDC_IDX_GATE_TWO:      s_d.rdata = s_q.gate_two;
        default:                        s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Feedback pin: normal ticks toggle it; a fault applies the setting.
    if (!fault_in)
    begin
      s_d.fb_drive = 1'b1;
      if (fb_tick_in)
      begin
        s_d.fb_level = ~s_q.fb_level;
      end
    end
    else
    begin
      case (fb_mode)
        mdc_pkg::MDC_FB_HIGH_Z:
        begin
          s_d.fb_drive = 1'b0;
        end
        mdc_pkg::MDC_FB_DRIVE_LOW:
        begin
          s_d.fb_drive = 1'b1;
          s_d.fb_level = 1'b0;
        end
        default:
        begin
          // Reserved code 3 behaves as code 0, the safest visible choice.
          s_d.fb_drive = 1'b1;
          if (fb_tick_in && !motor_stopped_in)
          begin
            s_d.fb_level = ~s_q.fb_level;
          end
        end
      endcase
    end
    // Two-flop synchroniser for the asynchronous outside clock pin.
    s_d.ext_meta = outside_clock_pin_in;
    s_d.ext_sync = s_q.ext_meta;
  end

  // State register with constant reset values.
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_q.pin_setup_two <= mdc_pkg::MDC_RST_PIN_SETUP_TWO;
      s_q.device_setup  <= mdc_pkg::MDC_RST_DEVICE_SETUP;
      s_q.gate_one      <= mdc_pkg::MDC_RST_GATE_ONE;
      s_q.gate_two      <= mdc_pkg::MDC_RST_GATE_TWO;
      s_q.rdata         <= 32'h0000_0000;
      s_q.fb_level      <= 1'b0;
      s_q.fb_drive      <= 1'b0;
      s_q.ext_meta      <= 1'b0;
      s_q.ext_sync      <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Decoded configuration driven to the motor control logic.
  assign rdata_out                 = s_q.rdata;
  assign speed_feedback_output_out = s_q.fb_level;
  assign speed_feedback_oe_out     = s_q.fb_drive;
  assign freq_mode_out  = (speed_input_source_in == mdc_pkg::MDC_SPD_FREQ_MODE);
  // Outside frequency mode the ceiling is meaningless, so it reads zero.
  assign full_speed_hz_out = freq_mode_out ?
    s_q.device_setup[mdc_pkg::MDC_MAX_FREQ_LSB +: mdc_pkg::MDC_MAX_FREQ_W] :
    15'h0000;
  assign sleep_select_out = s_q.device_setup[mdc_pkg::MDC_LOW_PWR_BIT];
  assign pwm_min_hz_out = s_q.device_setup[mdc_pkg::MDC_PWM_BAND_BIT] ?
    mdc_pkg::MDC_PWM_LO_MIN_HZ : mdc_pkg::MDC_PWM_HI_MIN_HZ;
  assign pwm_max_hz_out = s_q.device_setup[mdc_pkg::MDC_PWM_BAND_BIT] ?
    mdc_pkg::MDC_PWM_LO_MAX_HZ : mdc_pkg::MDC_PWM_HI_MAX_HZ;
  assign clk_cfg_out.spread_spectrum_modulation =
    ~s_q.device_setup[mdc_pkg::MDC_SPREAD_OFF_BIT];
  // Reserved source codes fall back to the internal oscillator.
  assign clk_cfg_out.use_outside_clock = (clk_src == mdc_pkg::MDC_CLK_EXTERNAL) &&
    s_q.device_setup[mdc_pkg::MDC_EXT_EN_BIT];
  assign clk_cfg_out.outside_clock_hz = mdc_pkg::MDC_EXT_BASE_HZ << ext_rate;
  // The pin is masked unless enabled, so a floating input cannot leak in.
  assign outside_clock_out = s_q.ext_sync &&
    s_q.device_setup[mdc_pkg::MDC_EXT_EN_BIT];

  // Checks on the bank and the feedback pin.
  property p_fb_hiz;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_HIGH_Z |=> !speed_feedback_oe_out;
  endproperty
  a_fb_hiz: assert property (p_fb_hiz) else $error("Feedback not released.");

  property p_fb_low;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_DRIVE_LOW
      |=> speed_feedback_oe_out && !speed_feedback_output_out;
  endproperty
  a_fb_low: assert property (p_fb_low) else $error("Feedback not held low.");

  property p_fb_toggle;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_KEEP_TOGGLE && fb_tick_in &&
      !motor_stopped_in |=> speed_feedback_output_out != $past(speed_feedback_output_out);
  endproperty
  a_fb_toggle: assert property (p_fb_toggle) else $error("Feedback stopped.");

  property p_dev_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_in && addr_in == {mdc_pkg::MDC_IDX_DEVICE_SETUP, 2'h0}
      |=> s_q.device_setup == $past(wdata_in);
  endproperty
  a_dev_write: assert property (p_dev_write) else $error("Device word lost.");

  property p_gate_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_in && addr_in == {mdc_pkg::MDC_IDX_GATE_TWO, 2'h0}
      |=> rdata_out == $past(s_q.gate_two);
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("Bad gate read.");

  property p_spread_off;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_in && addr_in == {mdc_pkg::MDC_IDX_DEVICE_SETUP, 2'h0} && wdata_in[14]
      |=> !clk_cfg_out.spread_spectrum_modulation;
  endproperty
  a_spread_off: assert property (p_spread_off) else $error("Spread spectrum still on.");

  property p_ext_sel;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_in && addr_in == {mdc_pkg::MDC_IDX_DEVICE_SETUP, 2'h0}
      |=> clk_cfg_out.use_outside_clock == ($past(wdata_in[9:8]) == 2'h3 &&
          $past(wdata_in[6]));
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("Clock source wrong.");

  property p_ext_rate;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    ext_rate == 3'h7 |-> clk_cfg_out.outside_clock_hz == 21'h0fa000;
  endproperty
  a_ext_rate: assert property (p_ext_rate) else $error("Clock rate wrong.");

  property p_ext_gate;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !s_q.device_setup[mdc_pkg::MDC_EXT_EN_BIT] |-> !outside_clock_out;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("Clock not masked.");

  property p_unmapped;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read nonzero.");

  property p_freq_mode;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    speed_input_source_in != 2'h3 |-> full_speed_hz_out == 15'h0000;
  endproperty
  a_freq_mode: assert property (p_freq_mode) else $error("Ceiling outside mode.");

  // Decoded write strobes shared by the checks below.
  logic dev_wr_chk;
  logic pin_wr_chk;
  assign dev_wr_chk = wr_in && (addr_in == {mdc_pkg::MDC_IDX_DEVICE_SETUP, 2'h0});
  assign pin_wr_chk = wr_in && (addr_in == {mdc_pkg::MDC_IDX_PIN_SETUP_TWO, 2'h0});

  // Device word fields reach their outputs the cycle after a write.
  property p_spread_on;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk && !wdata_in[14] |=> clk_cfg_out.spread_spectrum_modulation;
  endproperty
  a_spread_on: assert property (p_spread_on) else $error("Spread spectrum off.");

  property p_sleep;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk |=> sleep_select_out == $past(wdata_in[11]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("Low power state wrong.");

  property p_pwm_low;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk && wdata_in[10]
      |=> pwm_min_hz_out == 17'h0000a && pwm_max_hz_out == 17'h00145;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("Slow PWM band wrong.");

  property p_pwm_high;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk && !wdata_in[10]
      |=> pwm_min_hz_out == 17'h00145 && pwm_max_hz_out == 17'h186a0;
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("Fast PWM band wrong.");

  property p_full_speed;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk |=> speed_input_source_in != 2'h3 ||
      full_speed_hz_out == $past(wdata_in[30:16]);
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("Ceiling not taken.");

  property p_rate;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk |=> clk_cfg_out.outside_clock_hz == (21'h001f40 << $past(wdata_in[5:3]));
  endproperty
  a_rate: assert property (p_rate) else $error("Clock rate not doubled.");

  // Reserved source codes must never select the outside clock.
  property p_rsv_src;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    dev_wr_chk && (wdata_in[9:8] == 2'h1 || wdata_in[9:8] == 2'h2)
      |=> !clk_cfg_out.use_outside_clock;
  endproperty
  a_rsv_src: assert property (p_rsv_src) else $error("Reserved source used.");

  property p_dev_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_in && addr_in == {mdc_pkg::MDC_IDX_DEVICE_SETUP, 2'h0}
      |=> rdata_out == $past(s_q.device_setup);
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("Bad device read.");

  property p_gate_one_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_in && addr_in == {mdc_pkg::MDC_IDX_GATE_ONE, 2'h0}
      |=> rdata_out == $past(s_q.gate_one);
  endproperty
  a_gate_one_read: assert property (p_gate_one_read) else $error("Bad gate one read.");

  // Reserved bits of the pin word are kept exactly as written.
  property p_rsv_keep;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    pin_wr_chk |=> s_q.pin_setup_two == $past(wdata_in);
  endproperty
  a_rsv_keep: assert property (p_rsv_keep) else $error("Pin word not kept.");

  // Read data stand one cycle only, so an idle bus reads zero.
  property p_rdata_idle;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !rd_in |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data lingered.");

  // A stopped motor freezes the feedback level in the toggle setting.
  property p_fb_stopped;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_KEEP_TOGGLE && motor_stopped_in
      |=> $stable(speed_feedback_output_out);
  endproperty
  a_fb_stopped: assert property (p_fb_stopped) else $error("Feedback moved.");

  // The first cycle after reset is skipped: the enable is still in reset there.
  property p_fb_normal;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !fault_in && $past(reset_n_in) |=> speed_feedback_oe_out;
  endproperty
  a_fb_normal: assert property (p_fb_normal) else $error("Feedback not driven.");

  c_fault_hiz: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_HIGH_Z);
  c_ext_clock: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_cfg_out.use_outside_clock);
  c_gate_read: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_in && addr_in == {mdc_pkg::MDC_IDX_GATE_ONE, 2'h0});
  c_fault_low: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_in && fb_mode == mdc_pkg::MDC_FB_DRIVE_LOW);
  c_freq_mode: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    freq_mode_out && full_speed_hz_out != 15'h0000);

endmodule : mdc_regs

// ### shared/mdc_pkg.sv
// Package for the motor device configuration register bank.
// Assumes a single 10 MHz clock domain and a plain strobe register port.
package mdc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  MDC_IDX_PIN_SETUP_TWO = 8'ha6;
  localparam logic [7:0]  MDC_IDX_DEVICE_SETUP  = 8'ha8;
  localparam logic [7:0]  MDC_IDX_GATE_ONE      = 8'hac;
  localparam logic [7:0]  MDC_IDX_GATE_TWO      = 8'hae;
  localparam int          MDC_ADDR_W            = 10;

  // Reset values.
  localparam logic [31:0] MDC_RST_PIN_SETUP_TWO = 32'h0000_0000;
  localparam logic [31:0] MDC_RST_DEVICE_SETUP  = 32'h0000_0000;
  localparam logic [31:0] MDC_RST_GATE_ONE      = 32'h0022_8000;
  localparam logic [31:0] MDC_RST_GATE_TWO      = 32'h0120_0000;

  // Field positions.
  localparam int MDC_FB_FAULT_LSB  = 11;
  localparam int MDC_MAX_FREQ_LSB  = 16;
  localparam int MDC_MAX_FREQ_W    = 15;
  localparam int MDC_SPREAD_OFF_BIT = 14;
  localparam int MDC_LOW_PWR_BIT   = 11;
  localparam int MDC_PWM_BAND_BIT  = 10;
  localparam int MDC_CLK_SRC_LSB   = 8;
  localparam int MDC_EXT_EN_BIT    = 6;
  localparam int MDC_EXT_RATE_LSB  = 3;

  // Codes of the two-bit fields.
  localparam logic [1:0]  MDC_FB_KEEP_TOGGLE = 2'h0;
  localparam logic [1:0]  MDC_FB_HIGH_Z      = 2'h1;
  localparam logic [1:0]  MDC_FB_DRIVE_LOW   = 2'h2;
  localparam logic [1:0]  MDC_CLK_INTERNAL   = 2'h0;
  localparam logic [1:0]  MDC_CLK_EXTERNAL   = 2'h3;
  localparam logic [1:0]  MDC_SPD_FREQ_MODE  = 2'h3;

  // Frequencies in hertz.
  localparam logic [20:0] MDC_EXT_BASE_HZ    = 21'h001f40;
  localparam logic [16:0] MDC_PWM_HI_MIN_HZ  = 17'h00145;
  localparam logic [16:0] MDC_PWM_HI_MAX_HZ  = 17'h186a0;
  localparam logic [16:0] MDC_PWM_LO_MIN_HZ  = 17'h0000a;
  localparam logic [16:0] MDC_PWM_LO_MAX_HZ  = 17'h00145;

  // Clock setup handed to the oscillator logic.
  typedef struct packed {
    logic        spread_spectrum_modulation;
    logic        use_outside_clock;
    logic [20:0] outside_clock_hz;
  } mdc_clk_cfg_t;

  // Complete state of the register bank.
  typedef struct packed {
    logic [31:0] pin_setup_two;
    logic [31:0] device_setup;
    logic [31:0] gate_one;
    logic [31:0] gate_two;
    logic [31:0] rdata;
    logic        fb_level;
    logic        fb_drive;
    logic        ext_meta;
    logic        ext_sync;
  } mdc_state_t;

endpackage : mdc_pkg

// ### verification/motor_device_config_regs_bench.sv
// Self-checking testbench for the motor device configuration register bank.
// Assumes the design's strobe register port and its one-cycle pin latency.
`timescale 1ns/100ps
module motor_device_config_regs_bench;
  localparam logic [9:0] A_PIN = 10'h298;
  localparam logic [9:0] A_DEV = 10'h2a0;
  localparam logic [9:0] A_G1  = 10'h2b0;
  localparam logic [9:0] A_G2  = 10'h2b8;
  localparam logic [9:0] A_BAD = 10'h2a4;
  logic                  clk;
  logic                  rst_n;
  logic [9:0]            addr;
  logic [31:0]           wdata;
  logic                  wr;
  logic                  rd;
  logic [31:0]           rdata;
  logic                  fault;
  logic                  stopped;
  logic                  tick;
  logic [1:0]            spd_src;
  logic                  ext_pin;
  logic                  fb_out;
  logic                  fb_oe;
  logic [14:0]           full_hz;
  logic                  freq_mode;
  logic                  sleep_sel;
  logic [16:0]           pwm_min;
  logic [16:0]           pwm_max;
  logic                  ext_out;
  mdc_pkg::mdc_clk_cfg_t clk_cfg;
  int                    err_count;
  int                    n_compared;

  mdc_regs u_dut
  (
    .sys_clk_in                (clk),
    .reset_n_in                (rst_n),
    .addr_in                   (addr),
    .wdata_in                  (wdata),
    .wr_in                     (wr),
    .rd_in                     (rd),
    .rdata_out                 (rdata),
    .fault_in                  (fault),
    .motor_stopped_in          (stopped),
    .fb_tick_in                (tick),
    .speed_input_source_in     (spd_src),
    .outside_clock_pin_in      (ext_pin),
    .speed_feedback_output_out (fb_out),
    .speed_feedback_oe_out     (fb_oe),
    .full_speed_hz_out         (full_hz),
    .freq_mode_out             (freq_mode),
    .sleep_select_out          (sleep_sel),
    .pwm_min_hz_out            (pwm_min),
    .pwm_max_hz_out            (pwm_max),
    .outside_clock_out         (ext_out),
    .clk_cfg_out               (clk_cfg)
  );

  // 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compares a value; four-state equality so an unknown never matches.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One-cycle write strobe; the register holds the value after that edge.
  task wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  // One-cycle read strobe; data stand only in the following cycle.
  task rd_reg(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd_reg

  // Single feedback tick pulse, checked a settle step after it is taken.
  task tick_once(input logic e_out);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    #1 chk("fb_out", {31'h0, e_out}, {31'h0, fb_out});
  endtask : tick_once

  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Bounded run: a hang counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    err_count = 0; n_compared = 0; rst_n = 1'b0; addr = 10'h000; wdata = 32'h0;
    wr = 1'b0; rd = 1'b0; fault = 1'b0; stopped = 1'b0; tick = 1'b0;
    spd_src = 2'h0; ext_pin = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(A_PIN, 32'h0000_0000);
    rd_reg(A_DEV, 32'h0000_0000);
    rd_reg(A_G1, 32'h0022_8000);
    rd_reg(A_G2, 32'h0120_0000);
    chk("spread", 32'h1, {31'h0, clk_cfg.spread_spectrum_modulation});
    chk("pwm_max", 32'h0001_86a0, {15'h0, pwm_max});
    chk("pwm_min_hi", 32'h0000_0145, {15'h0, pwm_min});
    chk("standby", 32'h0, {31'h0, sleep_sel});
    $display("reset values done");
    // Reserved bits stored, unlisted offset ignored and silent.
    wr_reg(A_DEV, 32'h8000_b087);
    rd_reg(A_DEV, 32'h8000_b087);
    chk("spread_rsv", 32'h1, {31'h0, clk_cfg.spread_spectrum_modulation});
    wr_reg(A_G1, 32'h5a5a_a5a5);
    rd_reg(A_G1, 32'h5a5a_a5a5);
    wr_reg(A_G2, 32'h0f0f_f0f0);
    rd_reg(A_G2, 32'h0f0f_f0f0);
    wr_reg(A_BAD, 32'hffff_ffff);
    rd_reg(A_BAD, 32'h0000_0000);
    rd_reg(A_DEV, 32'h8000_b087);
    $display("read back done");
    // Mode bits of the device word.
    wr_reg(A_DEV, 32'h0000_4c00);
    chk("spread_off", 32'h0, {31'h0, clk_cfg.spread_spectrum_modulation});
    chk("sleep", 32'h1, {31'h0, sleep_sel});
    chk("pwm_min", 32'h0000_000a, {15'h0, pwm_min});
    chk("pwm_max_lo", 32'h0000_0145, {15'h0, pwm_max});
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(A_DEV, (32'(c) << 8) | 32'h0000_0040);
      chk("use_ext", 32'(c == 3), {31'h0, clk_cfg.use_outside_clock});
    end
    wr_reg(A_DEV, 32'h0000_0300);
    chk("use_ext_off", 32'h0, {31'h0, clk_cfg.use_outside_clock});
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(A_DEV, 32'(k) << 3);
      chk("ext_hz", 32'(mdc_pkg::MDC_EXT_BASE_HZ) << k, 32'(clk_cfg.outside_clock_hz));
    end
    // Full-speed ceiling applies only in frequency mode.
    wr_reg(A_DEV, 32'h1234_0000);
    @(posedge clk);
    spd_src <= 2'h3;
    @(posedge clk);
    #1 chk("full_hz", 32'h0000_1234, {17'h0, full_hz});
    chk("freq_mode", 32'h1, {31'h0, freq_mode});
    @(posedge clk);
    spd_src <= 2'h1;
    @(posedge clk);
    #1 chk("full_hz_off", 32'h0, {17'h0, full_hz});
    chk("freq_mode_off", 32'h0, {31'h0, freq_mode});
    $display("device fields done");
    // Outside clock pin passes through only while enabled.
    @(posedge clk);
    ext_pin <= 1'b1;
    wr_reg(A_DEV, 32'h0000_0300);
    repeat (5) @(posedge clk);
    #1 chk("ext_out_off", 32'h0, {31'h0, ext_out});
    wr_reg(A_DEV, 32'h0000_0340);
    repeat (4) @(posedge clk);
    #1 chk("ext_out_on", 32'h1, {31'h0, ext_out});
    $display("outside clock done");
    // Feedback pin under each fault setting.
    wr_reg(A_PIN, 32'h0000_0000);
    tick_once(1'b1);
    @(posedge clk);
    fault <= 1'b1;
    tick_once(1'b0);
    @(posedge clk);
    stopped <= 1'b1;
    tick_once(1'b0);
    chk("oe_toggle", 32'h1, {31'h0, fb_oe});
    wr_reg(A_PIN, 32'h0000_0800);
    @(posedge clk);
    #1 chk("oe_hiz", 32'h0, {31'h0, fb_oe});
    wr_reg(A_PIN, 32'h0000_1000);
    @(posedge clk);
    #1 chk("oe_low", 32'h1, {31'h0, fb_oe});
    chk("out_low", 32'h0, {31'h0, fb_out});
    // Reserved setting keeps the pin driven and toggling like setting 0.
    wr_reg(A_PIN, 32'h0000_1800);
    @(posedge clk);
    stopped <= 1'b0;
    tick_once(1'b1);
    chk("oe_rsv", 32'h1, {31'h0, fb_oe});
    $display("feedback pin done");
    results();
  end
endmodule : motor_device_config_regs_bench
